// file: csal_ctrl_model.sv
// disk controller model driving cylinder address and command strobe
`default_nettype none
module csal_ctrl_model
  import csal_pkg::*;
(
  input wire logic i_sys_clk,             // system clock
  input wire logic i_reset_n,             // async reset, active low
  input wire logic i_go,                  // bench asks for one strobe
  input wire logic [CYL_W-1:0] i_addr,    // address to send
  input wire logic i_ack,                 // accepted answer
  input wire logic i_invalid,             // invalid answer
  output logic o_strobe,                  // command strobe
  output logic [CYL_W-1:0] o_cyl_addr,    // cylinder address lines
  output logic o_unanswered               // sticky, a strobe got no answer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_q;
  // one-cycle strobe; idle address lines toggle so no stale value reads as valid
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_strobe <= 1'b0;
      o_cyl_addr <= '0;
      pend_q <= 1'b0;
      o_unanswered <= 1'b0;
    end else begin
      o_strobe <= i_go;
      o_cyl_addr <= i_go ? i_addr : ~o_cyl_addr;
      pend_q <= o_strobe;
      if (pend_q && (i_ack === i_invalid)) begin
        o_unanswered <= 1'b1;
      end
    end
  end
endmodule : csal_ctrl_model
`default_nettype wire

// file: csal_pkg.sv
// constants and field layout of the cylinder seek address logic
//
// Functional notes
// - valid strobed address pulses accepted acknowledge
// - address above 312 octal flags invalid
// - acceptance loads distance into remaining register
// - acceptance sets one motion flop, clears other
// - inward tick increments current cylinder inward
// - outward tick decrements current cylinder outward
// - inward tick reclocks flops and distance
// - outward tick reclocks flops and distance
// - remaining distance updated every cylinder crossed
// - all-cleared distance commands maximum velocity
// - all-set distance commands minimum velocity
// - upper zone flag above 177 octal
// - reduce write current while upper zone
// - every strobe answered accepted or invalid
// - seek incomplete on timeout or inner limit
// - outer limit clears addresses, sets restore
// - on-cylinder ready when positioned at target
`default_nettype none
package csal_pkg;
  localparam int CYL_W = 8;
  localparam int DIST_W = 5;
  localparam int CNT_W = 9;
  localparam logic [CYL_W-1:0] CYL_MAX = 8'hCA;        // 312 octal
  localparam logic [CYL_W-1:0] ZONE_LIMIT = 8'h7F;     // 177 octal
  localparam logic [DIST_W-1:0] DIST_ALL_SET = 5'h1F;
  localparam logic [DIST_W-1:0] DIST_ALL_CLR = 5'h00;
  localparam logic [CNT_W-1:0] DIST_SAT = 9'h01F;
  // seek timeout, printed in milliseconds
  localparam int SEEK_TIMEOUT_MS = 280;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEEK_TIMEOUT_CYC = SEEK_TIMEOUT_MS * (CLK_HZ / 1000);
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0C;
  // event bit positions in status, enable and clear
  localparam int EV_ACK = 0;
  localparam int EV_INVALID = 1;
  localparam int EV_SEEK_INC = 2;
  localparam int EV_ON_CYL = 3;
  localparam int EV_W = 4;
  // fields of the position register
  localparam int POS_TGT_LSB = 8;
  localparam int POS_DIST_LSB = 16;
  localparam int POS_FLAG_LSB = 24;
endpackage : csal_pkg
`default_nettype wire

// file: csal_top.sv
// cylinder seek address logic with apb status and interrupt registers
`default_nettype none
module csal_top
  import csal_pkg::*;
#(
  parameter int SEEK_LIMIT_CYC = SEEK_TIMEOUT_CYC
) (
  input wire logic i_sys_clk,                   // system clock, 100 MHz
  input wire logic i_reset_n,                   // async reset, active low
  input wire logic [CYL_W-1:0] i_cyl_addr,      // cylinder address from controller
  input wire logic i_strobe,                    // one-cycle command strobe
  input wire logic i_restore,                   // one-cycle restore request
  input wire logic i_inward_step_tick,          // one pulse per cylinder inward
  input wire logic i_outward_step_tick,         // one pulse per cylinder outward
  input wire logic i_outer_limit,               // outer limit sensed, level
  input wire logic i_inner_limit,               // inner limit sensed, level
  output logic o_cylinder_ok_ack,               // cylinder_ok_ack pulse
  output logic o_addr_invalid,                  // address invalid pulse
  output logic o_inward_motion_flop,            // inward motion wanted
  output logic o_outward_motion_flop,           // outward motion wanted
  output logic [DIST_W-1:0] o_remaining_distance_reg, // velocity code to servo
  output logic o_max_velocity,                  // full speed command
  output logic o_min_velocity,                  // slowest speed command
  output logic [CYL_W-1:0] o_current_cyl,       // current cylinder
  output logic o_upper_zone_flag,               // cylinder above 177 octal
  output logic o_reduce_write_current,          // to write logic
  output logic o_return_to_track_zero,          // restore flop
  output logic o_seek_incomplete,               // seek failed, sticky
  output logic o_on_cylinder,                   // positioned and ready
  output logic o_irq,                           // level interrupt
  input wire logic i_psel,                      // apb select
  input wire logic i_penable,                   // apb enable
  input wire logic i_pwrite,                    // apb direction
  input wire logic [7:0] i_paddr,               // apb byte address
  input wire logic [31:0] i_pwdata,             // apb write data
  output logic [31:0] o_prdata,                 // apb read data
  output logic o_pready,                        // apb ready
  output logic o_pslverr                        // apb error on unmapped
);

  logic [CYL_W-1:0] cur_q, cur_d, tgt_q, tgt_d;
  logic [CNT_W-1:0] dist_q, dist_d;
  logic [DIST_W-1:0] code_q, code_d;
  logic in_q, in_d, out_q, out_d, rtz_q, rtz_d;
  logic ack_q, ack_d, inv_q, inv_d, zone_q, zone_d;
  logic sinc_q, sinc_d, oncyl_q, oncyl_d;
  logic [31:0] tmr_q, tmr_d;
  logic [EV_W-1:0] stat_q, stat_d, en_q, en_d, ev;
  logic upd, timeout, wr, rd_ok;

  // seek sequencing: strobe check, tick counting, restore and limits
  always_comb begin
    cur_d = cur_q;
    tgt_d = tgt_q;
    in_d = in_q;
    out_d = out_q;
    rtz_d = rtz_q;
    dist_d = dist_q;
    ack_d = 1'b0;
    inv_d = 1'b0;
    if (i_strobe) begin
      if (i_cyl_addr > CYL_MAX) begin
        inv_d = 1'b1;
      end else begin
        ack_d = 1'b1;
        tgt_d = i_cyl_addr;
      end
    end
    if (i_inward_step_tick && in_q) begin
      cur_d = cur_q + 1'b1;
    end
    // count down going outward, never below zero
    if (i_outward_step_tick && out_q && cur_q != '0) begin
      cur_d = cur_q - 1'b1;
    end
    // opposite tick reclocks flops and distance
    upd = ack_d | (i_inward_step_tick & out_q) | (i_outward_step_tick & in_q)
      | (i_inward_step_tick & in_q) | (i_outward_step_tick & out_q);
    if (upd && !rtz_q) begin
      dist_d = (tgt_d > cur_d) ? {1'b0, tgt_d - cur_d} : {1'b0, cur_d - tgt_d};
      // inward flop set if target above, outward if below; both reset at target
      in_d = tgt_d > cur_d;
      out_d = tgt_d < cur_d;
    end
    // restore and inner limit drive the carriage outward to home
    if (i_restore || i_inner_limit) begin
      rtz_d = 1'b1;
      tgt_d = '0;
      in_d = 1'b0;
      out_d = 1'b1;
      dist_d = {1'b0, cur_q};
    end
    // restore ends once home has been reached and the limit released
    if (rtz_q && !out_q && !i_outer_limit) begin
      rtz_d = 1'b0;
    end
    // outer limit holds addresses cleared, restore set
    if (i_outer_limit) begin
      cur_d = '0;
      tgt_d = '0;
      dist_d = '0;
      rtz_d = 1'b1;
      out_d = 1'b0;
    end
    // upper zone from next cylinder so the flag stays registered
    zone_d = cur_d > ZONE_LIMIT;
  end

  // seek timer runs only while a motion flop is set
  always_comb begin
    tmr_d = (in_q || out_q) ? tmr_q + 32'h1 : 32'h0;
    timeout = (in_q || out_q) && (tmr_q == 32'(SEEK_LIMIT_CYC - 1));
    // timeout or inner limit, set wins over acceptance clear
    sinc_d = sinc_q;
    if (ack_q) begin
      sinc_d = 1'b0;
    end
    if (timeout || i_inner_limit) begin
      sinc_d = 1'b1;
    end
    // ready once no motion is wanted
    oncyl_d = !in_d && !out_d && !rtz_d;
    // five flops hold the code: cleared far away, all set on arrival
    // registering it keeps subtractor glitches off the servo lines
    code_d = (dist_d >= DIST_SAT) ? DIST_ALL_CLR
      : (DIST_ALL_SET - dist_d[DIST_W-1:0]);
  end

  // motion and position registers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_q <= '0;
      tgt_q <= '0;
      dist_q <= '0;
      code_q <= DIST_ALL_SET;
      in_q <= 1'b0;
      out_q <= 1'b0;
      rtz_q <= 1'b0;
      ack_q <= 1'b0;
      inv_q <= 1'b0;
      zone_q <= 1'b0;
      sinc_q <= 1'b0;
      oncyl_q <= 1'b0;
      tmr_q <= 32'h0;
    end else begin
      cur_q <= cur_d;
      tgt_q <= tgt_d;
      dist_q <= dist_d;
      code_q <= code_d;
      in_q <= in_d;
      out_q <= out_d;
      rtz_q <= rtz_d;
      ack_q <= ack_d;
      inv_q <= inv_d;
      zone_q <= zone_d;
      sinc_q <= sinc_d;
      oncyl_q <= oncyl_d;
      tmr_q <= tmr_d;
    end
  end

  // five-bit code straight from its flops
  assign o_remaining_distance_reg = code_q;
  assign o_max_velocity = o_remaining_distance_reg == DIST_ALL_CLR;
  assign o_min_velocity = o_remaining_distance_reg == DIST_ALL_SET;
  assign o_current_cyl = cur_q;
  assign o_upper_zone_flag = zone_q;
  // write current drops in the upper zone
  assign o_reduce_write_current = zone_q;
  assign o_cylinder_ok_ack = ack_q;
  assign o_addr_invalid = inv_q;
  assign o_inward_motion_flop = in_q;
  assign o_outward_motion_flop = out_q;
  assign o_return_to_track_zero = rtz_q;
  assign o_seek_incomplete = sinc_q;
  assign o_on_cylinder = oncyl_q;

  // sticky events; a set in the clearing cycle wins
  always_comb begin
    ev = '0;
    ev[EV_ACK] = ack_q;
    ev[EV_INVALID] = inv_q;
    ev[EV_SEEK_INC] = sinc_d & ~sinc_q;
    ev[EV_ON_CYL] = oncyl_d & ~oncyl_q;
    wr = i_psel && i_penable && i_pwrite;
    stat_d = stat_q;
    en_d = en_q;
    if (wr && i_paddr == ADDR_CLEAR) begin
      stat_d = stat_q & ~i_pwdata[EV_W-1:0];
    end
    if (wr && i_paddr == ADDR_ENABLE) begin
      en_d = i_pwdata[EV_W-1:0];
    end
    stat_d = stat_d | ev;
  end

  // interrupt registers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_q <= '0;
      en_q <= '0;
    end else begin
      stat_q <= stat_d;
      en_q <= en_d;
    end
  end

  assign o_irq = |(stat_q & en_q);

  // apb slave: zero wait states, unmapped addresses answer with error
  always_comb begin
    o_prdata = 32'h0;
    rd_ok = 1'b1;
    case (i_paddr)
      ADDR_STATUS: o_prdata[EV_W-1:0] = stat_q;
      ADDR_ENABLE: o_prdata[EV_W-1:0] = en_q;
      ADDR_CLEAR: o_prdata = 32'h0;
      ADDR_POS: begin
        o_prdata[CYL_W-1:0] = cur_q;
        o_prdata[POS_TGT_LSB +: CYL_W] = tgt_q;
        o_prdata[POS_DIST_LSB +: DIST_W] = o_remaining_distance_reg;
        o_prdata[POS_FLAG_LSB +: 4] = {rtz_q, zone_q, out_q, in_q};
      end
      default: rd_ok = 1'b0;
    endcase
  end
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !rd_ok;

  // checks sample on the system clock and rest while reset is low
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  AST_ACK_VALID: assert property (
    i_strobe && i_cyl_addr <= CYL_MAX && !i_outer_limit |=> o_cylinder_ok_ack && !o_addr_invalid)
    else $error("valid address not acknowledged");
  AST_INVALID: assert property (
    i_strobe && i_cyl_addr > CYL_MAX |=> o_addr_invalid && !o_cylinder_ok_ack)
    else $error("invalid address not flagged");
  AST_ANSWER: assert property (
    o_cylinder_ok_ack || o_addr_invalid |-> $past(i_strobe))
    else $error("answer without strobe");
  AST_DIR: assert property (
    i_strobe && i_cyl_addr <= CYL_MAX && i_cyl_addr > cur_q && !rtz_q
      && !i_inward_step_tick && !i_outward_step_tick
      && !i_restore && !i_inner_limit && !i_outer_limit |=> o_inward_motion_flop
      && !o_outward_motion_flop)
    else $error("inward flop not set for higher cylinder");
  AST_INC: assert property (
    i_inward_step_tick && in_q && !i_outward_step_tick && !i_outer_limit
      |=> cur_q == $past(cur_q) + 8'h01)
    else $error("current cylinder not incremented");
  AST_DEC: assert property (
    i_outward_step_tick && out_q && cur_q != 8'h00 && !i_outer_limit
      |=> cur_q == $past(cur_q) - 8'h01)
    else $error("current cylinder not decremented");
  AST_ZONE: assert property (
    ##1 o_upper_zone_flag == (cur_q > ZONE_LIMIT))
    else $error("upper zone flag disagrees with cylinder");
  AST_VEL: assert property (
    dist_q == 9'h000 |-> o_min_velocity && !o_max_velocity)
    else $error("arrived but not minimum velocity");
  AST_VELMAX: assert property (
    dist_q >= DIST_SAT |-> o_remaining_distance_reg == DIST_ALL_CLR && o_max_velocity)
    else $error("far from target but not maximum velocity");
  AST_DIST: assert property (
    i_inward_step_tick && in_q && dist_q != 9'h000 && !rtz_q && !i_strobe && !i_restore
      && !i_inner_limit && !i_outer_limit |=> dist_q == $past(dist_q) - 9'h001)
    else $error("remaining distance not stepped down");
  AST_INVKEEP: assert property (
    i_strobe && i_cyl_addr > CYL_MAX && !i_restore && !i_inner_limit && !i_outer_limit
      |=> $stable(tgt_q))
    else $error("invalid address changed the target");
  AST_SINC_CLR: assert property (
    ack_q && !timeout && !i_inner_limit |=> !o_seek_incomplete)
    else $error("seek incomplete not cleared by acceptance");
  AST_LIMIT: assert property (
    i_outer_limit |=> cur_q == 8'h00 && tgt_q == 8'h00 && o_return_to_track_zero)
    else $error("outer limit did not clear addresses");
  AST_SEEKINC: assert property (
    i_inner_limit |=> o_seek_incomplete)
    else $error("inner limit did not raise seek incomplete");
  AST_ONCYL: assert property (
    o_on_cylinder |-> !o_inward_motion_flop && !o_outward_motion_flop)
    else $error("on cylinder while moving");

  // main scenarios the bench should reach
  COV_ACCEPT: cover property (i_strobe && i_cyl_addr <= CYL_MAX ##1 o_cylinder_ok_ack);
  COV_RESTORE: cover property (o_return_to_track_zero ##1 !o_return_to_track_zero);
  COV_INVALID: cover property (o_addr_invalid);
  COV_ARRIVE: cover property (o_inward_motion_flop ##[1:300] o_on_cylinder);
  COV_TIMEOUT: cover property (timeout);

endmodule : csal_top
`default_nettype wire

// file: csal_top_test.sv
// self-checking bench of the cylinder seek address logic
`default_nettype none
module csal_top_test;
  import csal_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 50;
  logic clk = 0, rst_n = 0, go = 0, restore = 0, tin = 0, tout = 0, olim = 0, ilim = 0;
  logic psel = 0, pen = 0, pwr = 0, perr;
  logic [7:0] paddr = 8'h00, addr = 8'h00, cyl, cur;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic strobe, ack, inv, inm, outm, maxv, minv, zone, redw, return_to_track_zero, sinc, oncyl, irq, pready;
  logic pslverr, miss;
  logic [4:0] code;
  logic [7:0] ra [6] = '{8'h00, 8'hCB, 8'hFF, 8'hCA, 8'h1E, 8'h00};
  logic [10:0] rx [6] = '{11'h43F, 11'h23F, 11'h23F, 11'h540, 11'h501, 11'h43F};
  int err_count = 0, tests_run = 0;
  // free-running 100 MHz clock
  always #5 clk = ~clk;
  csal_top #(.SEEK_LIMIT_CYC(LIM)) dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_cyl_addr(cyl),
    .i_strobe(strobe), .i_restore(restore), .i_inward_step_tick(tin),
    .i_outward_step_tick(tout), .i_outer_limit(olim), .i_inner_limit(ilim),
    .o_cylinder_ok_ack(ack), .o_addr_invalid(inv), .o_inward_motion_flop(inm),
    .o_outward_motion_flop(outm), .o_remaining_distance_reg(code), .o_max_velocity(maxv),
    .o_min_velocity(minv), .o_current_cyl(cur), .o_upper_zone_flag(zone),
    .o_reduce_write_current(redw), .o_return_to_track_zero(return_to_track_zero), .o_seek_incomplete(sinc),
    .o_on_cylinder(oncyl), .o_irq(irq), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  csal_ctrl_model ctrl (.i_sys_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_addr(addr),
    .i_ack(ack), .i_invalid(inv), .o_strobe(strobe), .o_cyl_addr(cyl), .o_unanswered(miss));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task final_report;
    $display("mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // one strobe through the controller model, answer looked at in its cycle
  task seek(input logic [7:0] a);
    @(posedge clk);
    go <= 1'b1;
    addr <= a;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : seek
  task tick(input logic inward);
    @(posedge clk);
    if (inward) tin <= 1'b1;
    else tout <= 1'b1;
    @(posedge clk);
    tin <= 1'b0;
    tout <= 1'b0;
    @(negedge clk);
  endtask : tick
  task lim(input logic inner);
    @(posedge clk);
    if (inner) ilim <= 1'b1;
    else olim <= 1'b1;
    @(posedge clk);
    ilim <= 1'b0;
    @(negedge clk);
  endtask : lim
  // apb master: setup, access held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(negedge clk);
  endtask : apb
  // watchdog: the whole run needs well under 10 us
  initial begin
    #100000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({pready, minv, ack, inv, code, cur}, {4'hC, 5'h1F, 8'h00});
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(oncyl, 1'b1);
    for (int i = 0; i < 6; i++) begin
      seek(ra[i]);
      chk({ack, inv, inm, outm, maxv, minv, code}, rx[i]);
    end
    seek(8'h03);
    chk({inm, outm, code}, {2'b10, 5'h1C});
    tick(1'b0);
    chk(cur, 8'h00);
    for (int i = 1; i <= 3; i++) begin
      tick(1'b1);
      chk({cur, code}, {8'(i), 5'(28 + i)});
    end
    chk({inm, outm, oncyl, minv}, 4'h3);
    seek(8'h81);
    repeat (124) tick(1'b1);
    chk({cur, zone}, {8'h7F, 1'b0});
    tick(1'b1);
    chk({cur, zone, redw}, {8'h80, 2'b11});
    tick(1'b1);
    seek(8'h7F);
    chk({inm, outm}, 2'b01);
    tick(1'b0);
    tick(1'b1);
    chk(cur, 8'h80);
    tick(1'b0);
    chk({cur, zone, oncyl}, {8'h7F, 2'b01});
    // registers, unmapped access and interrupt raise, mask, clear
    apb(1'b0, ADDR_POS, 32'h0);
    chk(rd[15:0], 16'h7F7F);
    apb(1'b0, 8'h10, 32'h0);
    chk(perr, 1'b1);
    apb(1'b1, ADDR_CLEAR, 32'h0000000F);
    apb(1'b1, ADDR_ENABLE, 32'h0000000F);
    chk(irq, 1'b0);
    seek(8'h7F);
    @(negedge clk);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_ENABLE, 32'h0);
    chk(irq, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[3:0], 4'h1);
    apb(1'b1, ADDR_CLEAR, 32'h00000001);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[3:0], 4'h0);
    @(posedge clk);
    restore <= 1'b1;
    @(posedge clk);
    restore <= 1'b0;
    @(negedge clk);
    chk({return_to_track_zero, outm, inm}, 3'b110);
    lim(1'b0);
    chk({cur, return_to_track_zero, outm}, {8'h00, 2'b10});
    @(posedge clk);
    olim <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(return_to_track_zero, 1'b0);
    lim(1'b1);
    chk({sinc, return_to_track_zero}, 2'b11);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[3:0], 4'hC);
    lim(1'b0);
    @(posedge clk);
    olim <= 1'b0;
    repeat (2) @(posedge clk);
    seek(8'h00);
    seek(8'hCA);
    repeat (LIM + 5) @(posedge clk);
    @(negedge clk);
    chk({sinc, miss}, 2'b10);
    // reset in mid-seek: all back to rest, ready one edge after release
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk({inm, sinc, irq, minv, cur}, {4'h1, 8'h00});
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({oncyl, inm}, 2'b10);
    final_report();
  end
endmodule : csal_top_test
`default_nettype wire
